/* common/sbc_pkg.sv */
// constants, enums and carriers for the second_lin_channel_control control and flag readout bank
// assumes a 16-bit serial command word, msb first
package sbc_pkg;

	// ************************************************************
	// frame and timing
	// ************************************************************
	localparam int CMD_W      = 16;
	localparam int SYNC_DEPTH = 2;
	localparam int CLK_NS     = 100;
	localparam int SCLK_NS    = 800;
	localparam int HALF_SCLK_CYC = SCLK_NS / (2 * CLK_NS);

	// ************************************************************
	// register addresses (5-bit command address field)
	// ************************************************************
	localparam logic [4:0] ADDR_REG_FLAGS = 5'h0f;
	localparam logic [4:0] ADDR_CAN_FLAGS = 5'h10;
	localparam logic [4:0] ADDR_IO        = 5'h11;
	localparam logic [4:0] ADDR_ID        = 5'h12;
	localparam logic [4:0] ADDR_SECOND_LIN_CHANNEL_CONTROL      = 5'h14;

	// ************************************************************
	// second_lin_channel_control control register layout and reset
	// ************************************************************
	localparam int MODE_LSB     = 6;
	localparam int SLEW_LSB     = 4;
	localparam int TERM_BIT     = 2;
	localparam int VSUP_EXT_BIT = 0;
	localparam logic [7:0] SECOND_LIN_CHANNEL_CONTROL_CTRL_RST  = 8'h00;
	localparam logic [7:0] SECOND_LIN_CHANNEL_CONTROL_CTRL_MASK = 8'hf5;

	// ************************************************************
	// latched flag vector layout
	// ************************************************************
	localparam int REG_FLAG_W  = 16;
	localparam int CAN_FLAG_W  = 16;
	localparam int SECOND_LIN_CHANNEL_CONTROL_FLAG_W = 8;
	localparam int REG_FLAG_LSB  = 0;
	localparam int CAN_FLAG_LSB  = REG_FLAG_LSB + REG_FLAG_W;
	localparam int SECOND_LIN_CHANNEL_CONTROL_FLAG_LSB = CAN_FLAG_LSB + CAN_FLAG_W;
	localparam int FLAG_W        = SECOND_LIN_CHANNEL_CONTROL_FLAG_LSB + SECOND_LIN_CHANNEL_CONTROL_FLAG_W;
	localparam logic [FLAG_W-1:0] FLAG_RST = '0;

	typedef enum logic [1:0] {
		KIND_STATUS = 2'b00,
		KIND_WRITE  = 2'b01,
		KIND_RSVD   = 2'b10,
		KIND_FLAGS  = 2'b11
	} cmd_kind_e;

	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_UNUSED = 2'b01,
		MODE_WAKE   = 2'b10,
		MODE_TRX    = 2'b11
	} lin_mode_e;

	typedef enum logic [1:0] {
		RATE_20K  = 2'b00,
		RATE_10K  = 2'b01,
		RATE_FAST = 2'b10
	} edge_rate_e;

	typedef struct packed {
		cmd_kind_e  kind;
		logic [4:0] addr;
		logic       bit8;
		logic       byte_sel;
		logic [6:0] low_bits;
	} spi_cmd_s;

	typedef struct packed {
		lin_mode_e  mode;
		logic [1:0] slew;
		logic       rsv3;
		logic       term;
		logic       rsv1;
		logic       vsup_ext;
	} second_lin_channel_control_ctrl_s;

endpackage : sbc_pkg

/* rtl/lin_flag_readout.sv */
// second_lin_channel_control channel control register and latched flag / status readout
// assumes fault and status inputs are asynchronous levels, high = present
`timescale 1ns/100ps

module lin_flag_readout
	import sbc_pkg::*;
#(
	parameter logic [7:0] DEVICE_STATUS = 8'h00, // arbitrary
	parameter logic [4:0] DEVICE_ID     = 5'h05, // arbitrary
	parameter logic [1:0] PART_CODE     = 2'h1,  // arbitrary
	parameter logic       VDD_IS_5V     = 1'b1
) (
	input  wire logic                   clk_in,
	input  wire logic                   arst_n_in,
	input  wire logic                   spi_sclk_in,
	input  wire logic                   spi_cs_n_in,
	input  wire logic                   spi_mosi_in,
	output logic                        spi_miso_out,
	output logic                        spi_miso_oe_n_out,
	input  wire logic                   lin_transmit_input_in,
	input  wire logic                   second_battery_supply_low_in,
	input  wire logic                   bus_transceiver_regulator_on_in,
	input  wire logic [REG_FLAG_W-1:0]  reg_fault_in,
	input  wire logic [CAN_FLAG_W-1:0]  can_fault_in,
	input  wire logic [SECOND_LIN_CHANNEL_CONTROL_FLAG_W-1:0] second_lin_channel_control_fault_in,
	input  wire logic [7:0]             can_live_in,
	input  wire logic [7:0]             io_level_in,
	output logic                        lin_trx_enable_out,
	output logic                        lin_wake_enable_out,
	output edge_rate_e                  lin_edge_rate_out,
	output logic                        master_termination_switch_out,
	output logic                        lin_force_recessive_out,
	output logic [7:0]                  second_lin_channel_control_ctrl_out
);

	if (FLAG_W != REG_FLAG_W + CAN_FLAG_W + SECOND_LIN_CHANNEL_CONTROL_FLAG_W) begin : g_bad
		$error("lin_flag_readout: flag vector layout mismatch");
	end

	// ************************************************************
	// serial port
	// ************************************************************
	logic [CMD_W-1:0] rx_word;
	logic             frame_done;
	logic [CMD_W-1:0] resp_r, resp_nxt;
	spi_cmd_s         cmd;

	spi_shift_port #(
		.WORD_W (CMD_W)
	) i_spi_shift_port (
		.clk_in        (clk_in),
		.arst_n_in     (arst_n_in),
		.sclk_in       (spi_sclk_in),
		.cs_n_in       (spi_cs_n_in),
		.mosi_in       (spi_mosi_in),
		.tx_word_in    (resp_r),
		.rx_word_out   (rx_word),
		.done_out      (frame_done),
		.miso_out      (spi_miso_out),
		.miso_oe_n_out (spi_miso_oe_n_out)
	);

	assign cmd = spi_cmd_s'(rx_word);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	localparam int LIVE_W = FLAG_W + 16 + 3;

	logic [LIVE_W-1:0] live_meta_r;
	logic [LIVE_W-1:0] live_sync_r;
	logic [FLAG_W-1:0] fault_s;
	logic [7:0]        can_live_s;
	logic [7:0]        io_level_s;
	logic              txd_recessive_s;
	logic              supply_low_s;
	logic              regulator_on_s;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			live_meta_r <= '0;
			live_sync_r <= '0;
		end else begin
			live_meta_r <= {second_lin_channel_control_fault_in, can_fault_in, reg_fault_in,
				can_live_in, io_level_in, lin_transmit_input_in,
				second_battery_supply_low_in,
				bus_transceiver_regulator_on_in};
			live_sync_r <= live_meta_r;
		end
	end

	assign fault_s         = live_sync_r[LIVE_W-1 -: FLAG_W];
	assign can_live_s      = live_sync_r[18:11];
	assign io_level_s      = live_sync_r[10:3];
	assign txd_recessive_s = live_sync_r[2];
	assign supply_low_s    = live_sync_r[1];
	assign regulator_on_s  = live_sync_r[0];

	// ************************************************************
	// flag byte decoding
	// ************************************************************
	// mask of the flags one read command reaches: eight, or none outside the five flag bytes
	function automatic logic [FLAG_W-1:0] flag_mask(
		input logic [4:0] addr,
		input logic       sel
	);
		logic [FLAG_W-1:0] m;
		m = '0;
		case (addr)
			ADDR_REG_FLAGS: m[REG_FLAG_LSB + (sel ? 8 : 0) +: 8] = 8'hff;
			ADDR_CAN_FLAGS: m[CAN_FLAG_LSB + (sel ? 8 : 0) +: 8] = 8'hff;
			ADDR_SECOND_LIN_CHANNEL_CONTROL:      m[SECOND_LIN_CHANNEL_CONTROL_FLAG_LSB +: 8] = sel ? 8'h00 : 8'hff;
			default:        m = '0;
		endcase
		return m;
	endfunction : flag_mask

	// gathers the masked flags down to one byte
	function automatic logic [7:0] flag_byte(
		input logic [FLAG_W-1:0] flags,
		input logic [4:0]        addr,
		input logic              sel
	);
		logic [FLAG_W-1:0] picked;
		logic [7:0]        b;
		picked = flags & flag_mask(addr, sel);
		b      = 8'h00;
		for (int i = 0; i < FLAG_W / 8; i++) begin
			b = b | picked[i*8 +: 8];
		end
		return b;
	endfunction : flag_byte

	// ************************************************************
	// latched flags
	// ************************************************************
	logic [FLAG_W-1:0] flags_r, flags_nxt;
	logic [FLAG_W-1:0] clear_mask;
	logic              flag_read;

	always_comb begin
		flag_read  = frame_done && cmd.kind == KIND_FLAGS;
		clear_mask = flag_read ? flag_mask(cmd.addr, cmd.byte_sel) : '0;
		// a present fault sets and holds its flag, read or not
		flags_nxt  = fault_s | (flags_r & ~clear_mask);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			flags_r <= FLAG_RST;
		else
			flags_r <= flags_nxt;
	end

	// ************************************************************
	// second_lin_channel_control control register
	// ************************************************************
	second_lin_channel_control_ctrl_s ctrl_r, ctrl_nxt;
	second_lin_channel_control_ctrl_s wr_val;
	logic       ctrl_write;

	always_comb begin
		wr_val     = second_lin_channel_control_ctrl_s'(cmd.byte_sel ? {1'b1, cmd.low_bits}
			: {1'b0, cmd.low_bits});
		wr_val     = second_lin_channel_control_ctrl_s'(8'(wr_val) & SECOND_LIN_CHANNEL_CONTROL_CTRL_MASK);
		ctrl_write = frame_done && cmd.kind == KIND_WRITE
			&& cmd.addr == ADDR_SECOND_LIN_CHANNEL_CONTROL;
		ctrl_nxt   = ctrl_r;
		if (ctrl_write) begin
			// channel cannot enter transmit-receive with txd held dominant
			if (wr_val.mode != MODE_TRX || txd_recessive_s)
				ctrl_nxt = wr_val;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			ctrl_r <= second_lin_channel_control_ctrl_s'(SECOND_LIN_CHANNEL_CONTROL_CTRL_RST);
		else
			ctrl_r <= ctrl_nxt;
	end

	// ************************************************************
	// response word for the next frame
	// ************************************************************
	logic [7:0] status_byte;

	always_comb begin
		case (cmd.addr)
			ADDR_CAN_FLAGS: status_byte = can_live_s;
			ADDR_IO:        status_byte = io_level_s;
			ADDR_ID:        status_byte = {VDD_IS_5V, PART_CODE, DEVICE_ID};
			ADDR_SECOND_LIN_CHANNEL_CONTROL:      status_byte = {ctrl_r.mode == MODE_TRX,
				ctrl_r.mode == MODE_WAKE, 6'h00};
			default:        status_byte = 8'h00;
		endcase
		resp_nxt = resp_r;
		if (frame_done) begin
			case (cmd.kind)
				// address in bits 13:9, byte choice in bit 7
				KIND_FLAGS: resp_nxt = {DEVICE_STATUS,
					flag_byte(flags_r, cmd.addr, cmd.byte_sel)};
				KIND_STATUS: resp_nxt = {DEVICE_STATUS,
					status_byte};
				KIND_WRITE: resp_nxt = {DEVICE_STATUS, 8'h00};
				KIND_RSVD: resp_nxt = {DEVICE_STATUS, 8'h00};
				default: resp_nxt = {DEVICE_STATUS, 8'h00};
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			resp_r <= '0;
		else
			resp_r <= resp_nxt;
	end

	// ************************************************************
	// channel controls
	// ************************************************************
	logic       trx_r, trx_nxt;
	logic       wake_r, wake_nxt;
	edge_rate_e rate_r, rate_nxt;
	logic       term_r, term_nxt;
	logic       rec_r, rec_nxt;
	logic [7:0] ctrl_o_r, ctrl_o_nxt;

	always_comb begin
		trx_nxt  = ctrl_r.mode == MODE_TRX;
		wake_nxt = ctrl_r.mode == MODE_WAKE;
		case (ctrl_r.slew)
			2'b00:   rate_nxt = RATE_20K;
			2'b01:   rate_nxt = RATE_10K;
			default: rate_nxt = RATE_FAST;
		endcase
		term_nxt = ctrl_r.term;
		// the regulator feeds the channel; without it the bus idles
		rec_nxt  = !regulator_on_s
			|| (!ctrl_r.vsup_ext && supply_low_s);
		ctrl_o_nxt = 8'(ctrl_r);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			trx_r    <= 1'b0;
			wake_r   <= 1'b0;
			rate_r   <= RATE_20K;
			term_r   <= 1'b0;
			rec_r    <= 1'b1;
			ctrl_o_r <= SECOND_LIN_CHANNEL_CONTROL_CTRL_RST;
		end else begin
			trx_r    <= trx_nxt;
			wake_r   <= wake_nxt;
			rate_r   <= rate_nxt;
			term_r   <= term_nxt;
			rec_r    <= rec_nxt;
			ctrl_o_r <= ctrl_o_nxt;
		end
	end

	assign lin_trx_enable_out            = trx_r;
	assign lin_wake_enable_out           = wake_r;
	assign lin_edge_rate_out             = rate_r;
	assign master_termination_switch_out = term_r;
	assign lin_force_recessive_out       = rec_r;
	assign second_lin_channel_control_ctrl_out                 = ctrl_o_r;

endmodule : lin_flag_readout

/* rtl/spi_shift_port.sv */
// serial shift port: synchronises the link pins, shifts one word each way
// assumes mode 0 framing and a link clock far slower than clk_in
`timescale 1ns/100ps
module spi_shift_port
	import sbc_pkg::*;
#(
	parameter int WORD_W = CMD_W
) (
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              sclk_in,
	input  wire logic              cs_n_in,
	input  wire logic              mosi_in,
	input  wire logic [WORD_W-1:0] tx_word_in,
	output logic      [WORD_W-1:0] rx_word_out,
	output logic                   done_out,
	output logic                   miso_out,
	output logic                   miso_oe_n_out
);

	localparam int CNT_W = $clog2(WORD_W + 2);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(WORD_W);
	localparam logic [CNT_W-1:0] CNT_OVER = CNT_W'(WORD_W + 1);

	if (WORD_W < 2 || HALF_SCLK_CYC < 3) begin : g_bad_cfg
		$error("spi_shift_port: word too short or link clock too fast");
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	logic [1:0] dly_r;
	logic       mosi_s;
	logic       sclk_s;
	logic       cs_s;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			// idle levels: cs high, sclk low, so no false edge after reset
			meta_r <= 3'h4;
			sync_r <= 3'h4;
			dly_r  <= 2'h2;
		end else begin
			meta_r <= {cs_n_in, sclk_in, mosi_in};
			sync_r <= meta_r;
			dly_r  <= sync_r[2:1];
		end
	end

	assign mosi_s = sync_r[0];
	assign sclk_s = sync_r[1];
	assign cs_s   = sync_r[2];

	// ************************************************************
	// shifting
	// ************************************************************
	logic [WORD_W-1:0] rx_sr_r, rx_sr_nxt;
	logic [WORD_W-1:0] tx_sr_r, tx_sr_nxt;
	logic [WORD_W-1:0] rx_word_r, rx_word_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic              done_r, done_nxt;
	logic              oe_n_r, oe_n_nxt;
	logic              sclk_rise, sclk_fall, cs_fall, cs_rise;

	always_comb begin
		sclk_rise   = sclk_s & ~dly_r[0];
		sclk_fall   = ~sclk_s & dly_r[0];
		cs_fall     = ~cs_s & dly_r[1];
		cs_rise     = cs_s & ~dly_r[1];
		rx_sr_nxt   = rx_sr_r;
		tx_sr_nxt   = tx_sr_r;
		rx_word_nxt = rx_word_r;
		cnt_nxt     = cnt_r;
		done_nxt    = 1'b0;
		oe_n_nxt    = oe_n_r;
		if (cs_fall) begin
			tx_sr_nxt = tx_word_in;
			cnt_nxt   = '0;
			oe_n_nxt  = 1'b0;
		end else if (!cs_s) begin
			if (sclk_rise) begin
				rx_sr_nxt = {rx_sr_r[WORD_W-2:0], mosi_s};
				if (cnt_r != CNT_OVER)
					cnt_nxt = cnt_r + 1'b1;
			end
			if (sclk_fall && cnt_r != '0)
				tx_sr_nxt = {tx_sr_r[WORD_W-2:0], 1'b0};
		end
		if (cs_rise) begin
			oe_n_nxt = 1'b1;
			// only whole words count as commands
			if (cnt_r == CNT_FULL) begin
				done_nxt    = 1'b1;
				rx_word_nxt = rx_sr_r;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_sr_r   <= '0;
			tx_sr_r   <= '0;
			rx_word_r <= '0;
			cnt_r     <= '0;
			done_r    <= 1'b0;
			oe_n_r    <= 1'b1;
		end else begin
			rx_sr_r   <= rx_sr_nxt;
			tx_sr_r   <= tx_sr_nxt;
			rx_word_r <= rx_word_nxt;
			cnt_r     <= cnt_nxt;
			done_r    <= done_nxt;
			oe_n_r    <= oe_n_nxt;
		end
	end

	assign rx_word_out   = rx_word_r;
	assign done_out      = done_r;
	assign miso_out      = tx_sr_r[WORD_W-1];
	assign miso_oe_n_out = oe_n_r;

endmodule : spi_shift_port

/* verif/lin_flag_readout_assertions.sv */
// checker: second_lin_channel_control control outputs, forced recessive and miso enable
// assumes bound to lin_flag_readout; inputs steady around frames
`timescale 1ns/100ps
module lin_flag_readout_assertions
	import sbc_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       arst_n_in,
	input wire logic       spi_cs_n_in,
	input wire logic       spi_miso_oe_n_out,
	input wire logic       lin_transmit_input_in,
	input wire logic       second_battery_supply_low_in,
	input wire logic       bus_transceiver_regulator_on_in,
	input wire logic       lin_trx_enable_out,
	input wire logic       lin_wake_enable_out,
	input wire edge_rate_e lin_edge_rate_out,
	input wire logic       master_termination_switch_out,
	input wire logic       lin_force_recessive_out,
	input wire logic [7:0] second_lin_channel_control_ctrl_out
);
	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	AST_TRX_MODE: assert property (
		$stable(second_lin_channel_control_ctrl_out) [*2] |->
		lin_trx_enable_out == (second_lin_channel_control_ctrl_out[7:6] == 2'b11))
		else $error("trx enable not matching mode field");
	AST_WAKE_MODE: assert property (
		$stable(second_lin_channel_control_ctrl_out) [*2] |->
		lin_wake_enable_out == (second_lin_channel_control_ctrl_out[7:6] == 2'b10))
		else $error("wake enable not matching mode field");
	AST_EDGE_RATE: assert property (
		$stable(second_lin_channel_control_ctrl_out) [*2] |-> lin_edge_rate_out ==
		(second_lin_channel_control_ctrl_out[5] ? RATE_FAST : edge_rate_e'(second_lin_channel_control_ctrl_out[5:4])))
		else $error("edge rate not matching rate field");
	AST_TERM: assert property (
		$stable(second_lin_channel_control_ctrl_out) [*2] |->
		master_termination_switch_out == second_lin_channel_control_ctrl_out[2])
		else $error("termination not matching bit 2");
	AST_FORCE_ON: assert property (
		(!bus_transceiver_regulator_on_in || (second_battery_supply_low_in
		&& !second_lin_channel_control_ctrl_out[0])) [*6] |-> lin_force_recessive_out)
		else $error("channel not forced recessive");
	AST_FORCE_OFF: assert property (
		(bus_transceiver_regulator_on_in && (!second_battery_supply_low_in
		|| second_lin_channel_control_ctrl_out[0])) [*6] |-> !lin_force_recessive_out)
		else $error("channel forced recessive without cause");
	AST_TRX_REFUSED: assert property (
		$changed(second_lin_channel_control_ctrl_out) && second_lin_channel_control_ctrl_out[7:6] == 2'b11 |->
		$past(lin_transmit_input_in, 4))
		else $error("mode 11 taken while transmit input low");
	AST_OE_IDLE: assert property (
		spi_cs_n_in [*5] |-> spi_miso_oe_n_out)
		else $error("miso driven outside frame");
	AST_OE_DRIVE: assert property (
		!spi_cs_n_in [*5] |-> !spi_miso_oe_n_out)
		else $error("miso not driven inside frame");
endmodule : lin_flag_readout_assertions

bind lin_flag_readout lin_flag_readout_assertions
	i_lin_flag_readout_assertions (
	.clk_in, .arst_n_in, .spi_cs_n_in, .spi_miso_oe_n_out,
	.lin_transmit_input_in, .second_battery_supply_low_in,
	.bus_transceiver_regulator_on_in, .lin_trx_enable_out,
	.lin_wake_enable_out, .lin_edge_rate_out,
	.master_termination_switch_out, .lin_force_recessive_out,
	.second_lin_channel_control_ctrl_out
);

/* verif/lin_flag_readout_tb_top.sv */
// self-checking bench for the second_lin_channel_control control and flag readout bank
// assumes spi_master_model as far-side master, clk_in 10 MHz
`timescale 1ns/100ps
module lin_flag_readout_tb_top
	import sbc_pkg::*;
;
	// ************************************************************
	// bench
	// ************************************************************
	localparam logic [7:0] DEV_ST = 8'h3c; // arbitrary
	localparam logic [4:0] DEV_ID = 5'h0b; // arbitrary
	localparam logic [1:0] DEV_PN = 2'h2;  // arbitrary
	logic        clk, arst_n, start, slow, sclk, cs_n, mosi, miso, oe_n;
	logic        done, txd, supply_low, reg_on, trx, wake, term, frc;
	logic [4:0]  nbits;
	logic [15:0] cmd, resp, reg_f, can_f;
	logic [7:0]  lin_f, can_live, io_lvl, ctrl;
	edge_rate_e  rate;
	int          miscompares = 0;
	int          n_tests = 0;
	wire         miso_line = !oe_n ? miso : ~miso;

	lin_flag_readout #(.DEVICE_STATUS(DEV_ST), .DEVICE_ID(DEV_ID),
		.PART_CODE(DEV_PN), .VDD_IS_5V(1'b1)) i_lin_flag_readout (
		.clk_in(clk), .arst_n_in(arst_n), .spi_sclk_in(sclk),
		.spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
		.spi_miso_oe_n_out(oe_n), .lin_transmit_input_in(txd),
		.second_battery_supply_low_in(supply_low),
		.bus_transceiver_regulator_on_in(reg_on), .reg_fault_in(reg_f),
		.can_fault_in(can_f), .second_lin_channel_control_fault_in(lin_f),
		.can_live_in(can_live), .io_level_in(io_lvl),
		.lin_trx_enable_out(trx), .lin_wake_enable_out(wake),
		.lin_edge_rate_out(rate), .master_termination_switch_out(term),
		.lin_force_recessive_out(frc), .second_lin_channel_control_ctrl_out(ctrl));

	spi_master_model i_spi_master_model (.clk_in(clk), .start_in(start),
		.slow_in(slow), .nbits_in(nbits), .cmd_in(cmd),
		.miso_in(miso_line), .sclk_out(sclk), .cs_n_out(cs_n),
		.mosi_out(mosi), .resp_out(resp), .done_out(done));

	task automatic finish_test();
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic cmp(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic xfer(input logic [15:0] c, input logic [4:0] nb);
		int n;
		cmd <= c;
		nbits <= nb;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (done !== 1'b1 && n < 1000);
		if (done !== 1'b1) begin
			miscompares++;
			finish_test();
		end
	endtask : xfer

	task automatic wr(input logic [7:0] d);
		xfer({2'b01, ADDR_SECOND_LIN_CHANNEL_CONTROL, 1'b0, d}, 5'd16);
	endtask : wr

	task automatic rd(input string nm, input logic [15:0] c,
		input logic [7:0] e);
		xfer(c, 5'd16);
		xfer(16'h0000, 5'd16);
		cmp(nm, {DEV_ST, e}, resp);
	endtask : rd

	task automatic chk(input logic [7:0] c);
		cmp("ctrl", {8'h00, c & SECOND_LIN_CHANNEL_CONTROL_CTRL_MASK}, {8'h00, ctrl});
		cmp("mode", {14'h0, c[7:6] == 2'b11, c[7:6] == 2'b10},
			{14'h0, trx, wake});
		cmp("rate", {14'h0, (c[5] ? 2'b10 : c[5:4])}, {14'h0, rate});
		cmp("term", {15'h0, c[2]}, {15'h0, term});
	endtask : chk

	task automatic t_reset();
		chk(8'h00);
		cmp("oe_n", 16'h0001, {15'h0, oe_n});
		xfer(16'h0000, 5'd16);
		cmp("first resp", 16'h0000, resp);
	endtask : t_reset

	task automatic t_write();
		logic [7:0] v [6] = '{8'hff, 8'h50, 8'h80, 8'h24, 8'h00, 8'h11};
		foreach (v[i]) begin
			wr(v[i]);
			chk(v[i]);
			rd("second_lin_channel_control state", 16'h2980, {v[i][7:6] == 2'b11,
				v[i][7:6] == 2'b10, 6'h00});
		end
	endtask : t_write

	task automatic t_refused();
		wr(8'h44);
		txd <= 1'b0;
		cyc(6);
		wr(8'hc4);
		chk(8'h44);
		txd <= 1'b1;
		cyc(6);
		wr(8'hc4);
		chk(8'hc4);
	endtask : t_refused

	task automatic t_flags();
		reg_f <= 16'h81a5;
		lin_f <= 8'h12;
		cyc(4);
		reg_f <= '0;
		lin_f <= '0;
		cyc(4);
		rd("reg lo", 16'hdf00, 8'ha5);
		rd("reg lo again", 16'hdf00, 8'h00);
		rd("reg hi", 16'hdf80, 8'h81);
		rd("second_lin_channel_control flags", 16'he900, 8'h12);
		can_f <= 16'h3c00;
		cyc(4);
		rd("can hi", 16'he180, 8'h3c);
		rd("can hi held", 16'he180, 8'h3c);
		can_f <= '0;
		cyc(4);
		rd("can hi latched", 16'he180, 8'h3c);
		rd("can hi cleared", 16'he180, 8'h00);
	endtask : t_flags

	task automatic t_status();
		rd("io level", 16'h2380, io_lvl);
		rd("ident", 16'h2580, {1'b1, DEV_PN, DEV_ID});
		rd("can live", 16'h2180, can_live);
	endtask : t_status

	task automatic t_frames();
		slow <= 1'b1;
		wr(8'h20);
		slow <= 1'b0;
		chk(8'h20);
		xfer(16'h68ff, 5'd15);
		chk(8'h20);
		rd("rsvd kind", 16'ha9ff, 8'h00);
		chk(8'h20);
		xfer(16'h5eff, 5'd16);
		chk(8'h20);
	endtask : t_frames

	task automatic t_force();
		supply_low <= 1'b1;
		cyc(8);
		cmp("force low supply", 16'h0001, {15'h0, frc});
		wr(8'h21);
		cmp("force ext", 16'h0000, {15'h0, frc});
		reg_on <= 1'b0;
		cyc(8);
		cmp("force reg off", 16'h0001, {15'h0, frc});
		reg_on <= 1'b1;
		supply_low <= 1'b0;
		cyc(8);
		cmp("force clear", 16'h0000, {15'h0, frc});
	endtask : t_force

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#3000000;
		miscompares++;
		finish_test();
	end

	initial begin
		arst_n = 1'b0;
		start = 1'b0;
		slow = 1'b0;
		cmd = '0;
		nbits = 5'd16;
		txd = 1'b1;
		supply_low = 1'b0;
		reg_on = 1'b1;
		reg_f = '0;
		can_f = '0;
		lin_f = '0;
		can_live = 8'h5a;
		io_lvl = 8'hc3;
		cyc(4);
		arst_n <= 1'b1;
		cyc(6);
		t_reset();
		t_write();
		t_refused();
		t_flags();
		t_status();
		t_frames();
		t_force();
		finish_test();
	end
endmodule : lin_flag_readout_tb_top

/* verif/spi_master_model.sv */
// far-side master: one mode 0 frame, msb first, per start pulse
// assumes clk_in 100 ns; sclk 800 ns, or 1600 ns while slow_in
`timescale 1ns/100ps
module spi_master_model
	import sbc_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             start_in,
	input  wire logic             slow_in,
	input  wire logic [4:0]       nbits_in,
	input  wire logic [CMD_W-1:0] cmd_in,
	input  wire logic             miso_in,
	output logic                  sclk_out,
	output logic                  cs_n_out,
	output logic                  mosi_out,
	output logic      [CMD_W-1:0] resp_out,
	output logic                  done_out
);
	// ************************************************************
	// frame engine
	// ************************************************************
	int h;

	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
		done_out = 1'b0;
		resp_out = '0;
		forever begin
			@(posedge clk_in);
			done_out <= 1'b0;
			if (start_in === 1'b1) begin
				h = slow_in ? 8 : HALF_SCLK_CYC;
				cs_n_out <= 1'b0;
				for (int i = 0; i < nbits_in; i++) begin
					mosi_out <= cmd_in[CMD_W-1-i];
					wt(h);
					resp_out <= {resp_out[CMD_W-2:0], miso_in};
					sclk_out <= 1'b1;
					wt(h);
					sclk_out <= 1'b0;
				end
				wt(h);
				cs_n_out <= 1'b1;
				// released data line shows the inverse of its last bit
				mosi_out <= ~mosi_out;
				wt(8);
				done_out <= 1'b1;
			end
		end
	end
endmodule : spi_master_model
